/* File: logic/qhp_bus_if.sv */
`timescale 1ns/1ps
interface qhp_bus_if;
	logic bus_mode;
	logic bus_reset;
	logic chan_a_select_n;
	logic chan_b_select_n;
	logic chan_c_select_n;
	logic chan_d_select_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic rw_select_n;
	logic rw_read;
	logic chan_addr_hi;
	logic chan_addr_lo;
	logic [2:0] reg_addr;
	logic [7:0] host_data;
	logic host_data_oe;
	logic [7:0] dev_data;
	logic dev_data_oe;
	logic [7:0] data_bus;
	logic [3:0] chan_int;
	logic [3:0] rx_ready_n;
	logic [3:0] tx_ready_n;

	// shared data wire; undriven bus floats high as with a pull-up
	assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);

	modport dev (
		input bus_mode, bus_reset, chan_a_select_n, chan_b_select_n, chan_c_select_n,
		input chan_d_select_n, read_strobe_n, write_strobe_n, rw_select_n, rw_read,
		input chan_addr_hi, chan_addr_lo, reg_addr, data_bus,
		output dev_data, dev_data_oe, chan_int, rx_ready_n, tx_ready_n
	);
	modport host (
		output bus_mode, bus_reset, chan_a_select_n, chan_b_select_n, chan_c_select_n,
		output chan_d_select_n, read_strobe_n, write_strobe_n, rw_select_n, rw_read,
		output chan_addr_hi, chan_addr_lo, reg_addr, host_data, host_data_oe,
		input data_bus, chan_int, rx_ready_n, tx_ready_n
	);
endinterface

/* File: logic/qhp_dev_end.sv */
`timescale 1ns/1ps
module qhp_dev_end (
	input wire logic ref_clk,
	input wire logic resetn,
	qhp_bus_if.dev bus,
	input wire logic [3:0] fifo_en,
	input wire logic [3:0] block_mode,
	input wire logic [3:0] rx_has_data,
	input wire logic [3:0] rx_trig_reached,
	input wire logic [3:0] rx_timeout,
	input wire logic [3:0] tx_empty,
	input wire logic [3:0] tx_above_trig,
	input wire logic [3:0] tx_full,
	input wire logic [31:0] reg_rdata,
	output logic [3:0] reg_wr,
	output logic [3:0] reg_rd,
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic chan_reset
);

	////////////////////////////////////////////////////////////////////////////////
	// bus style and channel decode

	// mode pin high picks the strobe style
	wire strobe_mode = (bus.bus_mode == qhp_pkg::QHP_MODE_STROBE);
	// reset pin polarity follows the bus style
	wire reset_now = strobe_mode ? bus.bus_reset : ~bus.bus_reset;

	// per-channel selects, active low
	wire [3:0] sel_strobe = ~{bus.chan_d_select_n, bus.chan_c_select_n,
		bus.chan_b_select_n, bus.chan_a_select_n};
	// address bits only matter with the single select low
	wire [3:0] sel_rw = bus.rw_select_n ? 4'h0 :
		qhp_pkg::qhp_chan_onehot({bus.chan_addr_hi, bus.chan_addr_lo});
	// address bits ignored in strobe style
	wire [3:0] sel_now = strobe_mode ? sel_strobe : sel_rw;
	wire any_sel = |sel_now;

	// read and write are pure strobe/select decodes, no oscillator involved
	wire rd_now = strobe_mode ? (~bus.read_strobe_n & any_sel)
		: (~bus.rw_select_n & bus.rw_read);
	wire wr_now = strobe_mode ? (~bus.write_strobe_n & any_sel)
		: (~bus.rw_select_n & ~bus.rw_read);

	// lowest selected channel supplies read data; host never reads a broadcast
	wire [1:0] rd_chan = qhp_pkg::qhp_chan_code(sel_now);
	wire [7:0] rd_byte = reg_rdata[{rd_chan, 3'h0} +: 8];

	////////////////////////////////////////////////////////////////////////////////
	// reset pulse qualifier

	logic [3:0] rst_cnt;
	wire rst_full = (rst_cnt >= 4'(qhp_pkg::RESET_CYC));
	wire [3:0] next_rst_cnt = !reset_now ? 4'h0 : (rst_full ? rst_cnt : rst_cnt + 4'h1);

	// counts consecutive samples; RESET_CYC is 1, so a glitch caught by a single sample already resets
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rst_cnt <= 4'h0;
		else
			rst_cnt <= next_rst_cnt;
	end

	wire next_chan_reset = reset_now && (next_rst_cnt >= 4'(qhp_pkg::RESET_CYC));

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			chan_reset <= 1'b1;
		else
			chan_reset <= next_chan_reset;
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus cycle capture

	logic wr_q;
	logic rd_q;
	logic [3:0] sel_q;
	logic [2:0] addr_q;
	logic [7:0] data_q;

	// latch select and address while a strobe is active, data only while a write is active
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			sel_q <= 4'h0;
			addr_q <= 3'h0;
			data_q <= qhp_pkg::DATA_RST;
		end
		else
		begin
			wr_q <= wr_now & ~next_chan_reset;
			rd_q <= rd_now & ~next_chan_reset;
			if (wr_now | rd_now)
			begin
				sel_q <= sel_now;
				addr_q <= bus.reg_addr;
			end
			if (wr_now)
				data_q <= bus.data_bus;
		end
	end

	// commit on the trailing edge, where data has had the whole strobe to settle
	wire wr_end = wr_q & ~wr_now;
	wire rd_end = rd_q & ~rd_now;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reg_wr <= 4'h0;
			reg_rd <= 4'h0;
			reg_addr <= 3'h0;
			reg_wdata <= qhp_pkg::DATA_RST;
		end
		else
		begin
			reg_wr <= wr_end ? sel_q : 4'h0;
			reg_rd <= rd_end ? (4'h1 << qhp_pkg::qhp_chan_code(sel_q)) : 4'h0;
			if (wr_end | rd_end)
				reg_addr <= addr_q;
			if (wr_end)
				reg_wdata <= data_q;
		end
	end

	// data bus driven one ref_clk cycle behind the read of a selected channel, and released one cycle after it ends
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.dev_data_oe <= 1'b0;
			bus.dev_data <= qhp_pkg::DATA_RST;
		end
		else
		begin
			bus.dev_data_oe <= rd_now & ~next_chan_reset;
			bus.dev_data <= rd_now ? rd_byte : qhp_pkg::DATA_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt and ready outputs, one register stage per channel

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_chan
			wire fifo_on = fifo_en[ch];
			wire blk_on = fifo_on & block_mode[ch];

			// transmit interrupt: holding empty, or FIFO not above trigger in block mode
			wire int_tx = blk_on ? ~tx_above_trig[ch] : tx_empty[ch];
			// receive interrupt: any byte without FIFO, trigger level with FIFO
			wire int_rx = fifo_on ? rx_trig_reached[ch] : rx_has_data[ch];

			// block-mode receive ready: falls on trigger or timeout, rises only when empty
			logic rx_blk_n;
			wire rx_fall = rx_trig_reached[ch] | rx_timeout[ch];
			wire next_rx_blk_n = rx_fall ? 1'b0
				: (~rx_has_data[ch] ? 1'b1 : rx_blk_n);

			wire rx_rdy_n = blk_on ? next_rx_blk_n : ~rx_has_data[ch];
			wire tx_rdy_n = blk_on ? tx_full[ch] : ~tx_empty[ch];

			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
					rx_blk_n <= 1'b1;
				else if (next_chan_reset)
					rx_blk_n <= 1'b1;
				else
					rx_blk_n <= next_rx_blk_n;
			end

			// registered outputs; reset forces interrupt off and not ready
			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					bus.chan_int[ch] <= 1'b0;
					bus.rx_ready_n[ch] <= 1'b1;
					bus.tx_ready_n[ch] <= 1'b1;
				end
				else if (next_chan_reset)
				begin
					bus.chan_int[ch] <= 1'b0;
					bus.rx_ready_n[ch] <= 1'b1;
					bus.tx_ready_n[ch] <= 1'b1;
				end
				else
				begin
					bus.chan_int[ch] <= int_tx | int_rx;
					bus.rx_ready_n[ch] <= rx_rdy_n;
					bus.tx_ready_n[ch] <= tx_rdy_n;
				end
			end
		end
	endgenerate

endmodule // qhp_dev_end

/* File: logic/qhp_host_end.sv */
`timescale 1ns/1ps
module qhp_host_end (
	input wire logic ref_clk,
	input wire logic resetn,
	qhp_bus_if.host bus,
	input wire logic strobe_mode_sel,
	input wire logic rst_req,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [3:0] cmd_chan,
	input wire logic [2:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic cmd_refused,
	output logic rd_valid,
	output logic [7:0] rd_data
);

	typedef enum logic [2:0] {HS_IDLE, HS_RST, HS_SETUP, HS_STROBE, HS_RECOVER} qhp_hstate_t;

	qhp_hstate_t state;
	logic [3:0] cnt;
	logic wr_q;
	logic rst_on;

	////////////////////////////////////////////////////////////////////////////////
	// command check

	wire one_chan = (cmd_chan != 4'h0) && ((cmd_chan & (cmd_chan - 4'h1)) == 4'h0);
	// broadcast only for writes in strobe style; a multi-select read would collide
	wire cmd_ok = strobe_mode_sel ? (cmd_write ? (cmd_chan != 4'h0) : one_chan) : one_chan;
	wire take = cmd_ready & cmd_valid;
	wire strobe_style = (bus.bus_mode == qhp_pkg::QHP_MODE_STROBE);
	// style the pins carry after this edge; reset polarity must track it, not lag it
	wire next_strobe = (state == HS_IDLE) ? strobe_mode_sel : strobe_style;
	wire [3:0] sel_onehot = cmd_chan;
	wire [1:0] sel_code = qhp_pkg::qhp_chan_code(cmd_chan);

	////////////////////////////////////////////////////////////////////////////////
	// bus cycle sequencer

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= HS_IDLE;
			cnt <= 4'h0;
			wr_q <= 1'b0;
			rst_on <= 1'b0;
			cmd_ready <= 1'b0;
			cmd_refused <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= qhp_pkg::DATA_RST;
			bus.bus_mode <= qhp_pkg::QHP_MODE_STROBE;
			bus.bus_reset <= 1'b0;
			{bus.chan_d_select_n, bus.chan_c_select_n,
				bus.chan_b_select_n, bus.chan_a_select_n} <= qhp_pkg::SEL_IDLE;
			bus.read_strobe_n <= 1'b1;
			bus.write_strobe_n <= 1'b1;
			bus.rw_select_n <= 1'b1;
			bus.rw_read <= 1'b1;
			bus.chan_addr_hi <= 1'b0;
			bus.chan_addr_lo <= 1'b0;
			bus.reg_addr <= 3'h0;
			bus.host_data <= qhp_pkg::DATA_RST;
			bus.host_data_oe <= 1'b0;
		end
		else
		begin
			cmd_refused <= 1'b0;
			rd_valid <= 1'b0;
			// reset pin level follows the chosen polarity
			bus.bus_reset <= next_strobe ? rst_on : ~rst_on;
			case (state)
				HS_IDLE:
				begin
					bus.bus_mode <= strobe_mode_sel ? qhp_pkg::QHP_MODE_STROBE
						: qhp_pkg::QHP_MODE_RW;
					if (rst_req)
					begin
						cmd_ready <= 1'b0;
						rst_on <= 1'b1;
						cnt <= 4'h0;
						state <= HS_RST;
					end
					else if (take && !cmd_ok)
						cmd_refused <= 1'b1;
					else if (take)
					begin
						cmd_ready <= 1'b0;
						wr_q <= cmd_write;
						bus.reg_addr <= cmd_addr;
						bus.host_data <= cmd_wdata;
						bus.host_data_oe <= cmd_write;
						if (strobe_mode_sel)
							{bus.chan_d_select_n, bus.chan_c_select_n,
								bus.chan_b_select_n, bus.chan_a_select_n} <= ~sel_onehot;
						else
						begin
							bus.rw_read <= ~cmd_write;
							{bus.chan_addr_hi, bus.chan_addr_lo} <= sel_code;
						end
						state <= HS_SETUP;
					end
					else
						cmd_ready <= 1'b1;
				end
				HS_RST:
				begin
					// held one sample past the least width
					cnt <= cnt + 4'h1;
					if (cnt == 4'(qhp_pkg::RESET_HOLD_CYC - 1))
					begin
						rst_on <= 1'b0;
						state <= HS_IDLE;
					end
				end
				HS_SETUP:
				begin
					cnt <= 4'h0;
					if (strobe_style)
					begin
						bus.read_strobe_n <= wr_q;
						bus.write_strobe_n <= ~wr_q;
					end
					else
						bus.rw_select_n <= 1'b0;
					state <= HS_STROBE;
				end
				HS_STROBE:
				begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'(qhp_pkg::STROBE_CYC - 1))
					begin
						if (!wr_q)
						begin
							rd_data <= bus.data_bus;
							rd_valid <= 1'b1;
						end
						bus.read_strobe_n <= 1'b1;
						bus.write_strobe_n <= 1'b1;
						bus.rw_select_n <= 1'b1;
						state <= HS_RECOVER;
					end
				end
				default:
				begin
					{bus.chan_d_select_n, bus.chan_c_select_n,
						bus.chan_b_select_n, bus.chan_a_select_n} <= qhp_pkg::SEL_IDLE;
					bus.host_data_oe <= 1'b0;
					bus.rw_read <= 1'b1;
					cmd_ready <= 1'b1;
					state <= HS_IDLE;
				end
			endcase
		end
	end

endmodule // qhp_host_end

/* File: logic/qhp_pkg.sv */
package qhp_pkg;
	// channel count and bus widths
	localparam int CHAN_NUM = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;

	// reference clock and reset pulse timing
	localparam int CLK_MHZ = 25;
	localparam int RESET_MIN_NS = 40;
	// least time rounds up; "longer than" adds one sample for the host
	localparam int RESET_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_HOLD_CYC = RESET_CYC + 1;

	// host bus cycle timing, in ref_clk cycles
	localparam int STROBE_CYC = 3;

	// values after reset
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [3:0] SEL_IDLE = 4'hf;

	typedef enum logic {QHP_MODE_RW, QHP_MODE_STROBE} qhp_mode_t;

	// two channel address bits to a one-hot channel select
	function automatic logic [3:0] qhp_chan_onehot(input logic [1:0] code);
		qhp_chan_onehot = 4'h1 << code;
	endfunction

	// lowest selected channel to its two-bit code
	function automatic logic [1:0] qhp_chan_code(input logic [3:0] sel);
		qhp_chan_code = sel[0] ? 2'h0 : sel[1] ? 2'h1 : sel[2] ? 2'h2 : 2'h3;
	endfunction
endpackage

/* File: verif/qhp_chk_sva.sv */
`timescale 1ns/1ps
////////////////////////////////////////
module qhp_chk_sva (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic bus_mode,
	input wire logic bus_reset,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic chan_c_select_n,
	input wire logic chan_d_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic rw_select_n,
	input wire logic rw_read,
	input wire logic chan_addr_hi,
	input wire logic chan_addr_lo,
	input wire logic [7:0] host_data,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic [3:0] chan_int,
	input wire logic [3:0] rx_ready_n,
	input wire logic [3:0] tx_ready_n
);
	// decoded bus state; reset pin polarity follows the bus style
	wire [3:0] sel_n = {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};
	wire rd_act = bus_mode ? (!read_strobe_n && sel_n != 4'hf) : (!rw_select_n && rw_read);
	wire rst_act = bus_mode ? bus_reset : !bus_reset;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////
	no_bcast_read_a: assert property (bus_mode && !read_strobe_n |-> sel_n != 4'h0)
		else $error("read with all channels selected");
	oe_cause_a: assert property ($rose(dev_data_oe) |-> $past(rd_act))
		else $error("device drove data without a read");
	oe_release_a: assert property (!rd_act ##1 !rd_act |-> !dev_data_oe)
		else $error("device kept the data bus after the read");
	reset_idle_a: assert property (rst_act ##1 rst_act |->
		chan_int == 4'h0 && rx_ready_n == 4'hf && tx_ready_n == 4'hf)
		else $error("outputs active during bus reset");
	strobe_len_a: assert property ($fell(write_strobe_n) |->
		!write_strobe_n [*3] ##1 write_strobe_n)
		else $error("write strobe width wrong");
	select_len_a: assert property (!bus_mode && $fell(rw_select_n) |->
		!rw_select_n [*3] ##1 rw_select_n)
		else $error("chip select width wrong");
	write_has_sel_a: assert property (bus_mode && !write_strobe_n |-> sel_n != 4'hf)
		else $error("write strobe with no channel selected");
	data_hold_a: assert property (!write_strobe_n && !$past(write_strobe_n) |->
		host_data_oe && $stable(host_data))
		else $error("write data moved during strobe");
	addr_hold_a: assert property (!bus_mode && !rw_select_n |->
		$stable({chan_addr_hi, chan_addr_lo, rw_read}))
		else $error("channel address moved during cycle");
	style_pins_a: assert property (bus_mode ? rw_select_n
		: (read_strobe_n && write_strobe_n))
		else $error("pins of the other bus style active");
	mode_reset_a: assert property ($changed(bus_mode) |-> !rst_act)
		else $error("bus style change asserted reset");
endmodule // qhp_chk_sva

/* File: verif/test_quad_uart_host_port_ready_logic.sv */
`timescale 1ns/1ps
module test_quad_uart_host_port_ready_logic;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] fifo_en, block_mode, rx_has_data, rx_trig_reached, rx_timeout;
	logic [3:0] tx_empty, tx_above_trig, tx_full, reg_wr, reg_rd, wr_seen, rd_seen, cmd_chan;
	logic [31:0] reg_rdata = 32'hd4c3b2a1;
	logic [2:0] reg_addr, cmd_addr, got_addr;
	logic [7:0] reg_wdata, cmd_wdata, rd_data, got_byte;
	logic chan_reset, strobe_mode_sel, rst_req, cmd_valid, cmd_write, cmd_ready;
	logic cmd_refused, rd_valid, ref_seen, val_seen;
	int failures = 0;
	int cmp_count = 0;
	// fifo,block,rx data,trig,timeout,tx empty,above,full | int,rx_ready_n,tx_ready_n
	logic [10:0] rows [9] = '{11'b00010010_011, 11'b00100000_101, 11'b00000100_110,
		11'b10100000_001, 11'b10010001_111, 11'b10000100_110, 11'b11000010_010,
		11'b11000011_011, 11'b11000100_110};
	// block receive steps: the state must hold between trigger and empty
	logic [8:0] blk [6] = '{9'b11100000_1, 9'b11110000_0, 9'b11100000_0, 9'b11000000_1,
		9'b11101000_0, 9'b11000000_1};

	qhp_bus_if bus_if ();
	// device outputs seen through the carrier
	wire [3:0] chan_int = bus_if.chan_int;
	wire [3:0] rx_ready_n = bus_if.rx_ready_n;
	wire [3:0] tx_ready_n = bus_if.tx_ready_n;

	always #20 ref_clk = ~ref_clk;

	qhp_dev_end qhp_dev_end_inst (.ref_clk, .resetn, .bus(bus_if), .fifo_en, .block_mode,
		.rx_has_data, .rx_trig_reached, .rx_timeout, .tx_empty, .tx_above_trig, .tx_full,
		.reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .chan_reset);
	qhp_host_end qhp_host_end_inst (.ref_clk, .resetn, .bus(bus_if), .strobe_mode_sel, .rst_req,
		.cmd_valid, .cmd_write, .cmd_chan, .cmd_addr, .cmd_wdata, .cmd_ready, .cmd_refused,
		.rd_valid, .rd_data);
	qhp_chk_sva qhp_chk_sva_inst (.ref_clk, .resetn, .bus_mode(bus_if.bus_mode),
		.bus_reset(bus_if.bus_reset), .chan_a_select_n(bus_if.chan_a_select_n),
		.chan_b_select_n(bus_if.chan_b_select_n), .chan_c_select_n(bus_if.chan_c_select_n),
		.chan_d_select_n(bus_if.chan_d_select_n), .read_strobe_n(bus_if.read_strobe_n),
		.write_strobe_n(bus_if.write_strobe_n), .rw_select_n(bus_if.rw_select_n),
		.rw_read(bus_if.rw_read), .chan_addr_hi(bus_if.chan_addr_hi),
		.chan_addr_lo(bus_if.chan_addr_lo), .host_data(bus_if.host_data),
		.host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
		.chan_int(bus_if.chan_int), .rx_ready_n(bus_if.rx_ready_n),
		.tx_ready_n(bus_if.tx_ready_n));

	////////////////////////////////////////
	// latch one-cycle pulses so tests can look at them after the cycle
	always @(posedge ref_clk)
	begin
		if (reg_wr != 4'h0) {wr_seen, got_byte, got_addr} <= {reg_wr, reg_wdata, reg_addr};
		if (reg_rd != 4'h0) {rd_seen, got_addr} <= {reg_rd, reg_addr};
		if (cmd_refused === 1'b1) ref_seen <= 1'b1;
		if (rd_valid === 1'b1) val_seen <= 1'b1;
	end

	task automatic set_in(input logic [7:0] v);
		fifo_en = {4{v[7]}};
		block_mode = {4{v[6]}};
		rx_has_data = {4{v[5]}};
		rx_trig_reached = {4{v[4]}};
		rx_timeout = {4{v[3]}};
		tx_empty = {4{v[2]}};
		tx_above_trig = {4{v[1]}};
		tx_full = {4{v[0]}};
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one host command; waits out the fixed six-edge cycle before returning
	task automatic cmd(input logic w, input logic [3:0] ch, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		{wr_seen, rd_seen, ref_seen, val_seen} = 10'h0;
		{cmd_valid, cmd_write, cmd_chan, cmd_addr, cmd_wdata} = {1'b1, w, ch, a, d};
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		repeat (7) @(negedge ref_clk);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (4000) @(posedge ref_clk);
		failures++;
		end_of_test();
	end

	// main sequence: reset, table rows, then block, bus and reset-pin cases
	initial
	begin
		set_in(8'b00100100);
		{strobe_mode_sel, rst_req, cmd_valid, cmd_write, cmd_chan, cmd_addr, cmd_wdata} = 19'h40000;
		{wr_seen, rd_seen, ref_seen, val_seen} = 10'h0;
		repeat (10) @(negedge ref_clk);
		chk("reset int", 8'(chan_int), 8'h00);
		chk("reset ready", {rx_ready_n, tx_ready_n}, 8'hff);
		resetn = 1'b1;
		$display("test reset done");
		foreach (rows[i])
		begin
			set_in(rows[i][10:3]);
			repeat (2) @(negedge ref_clk);
			chk("interrupt", 8'(chan_int), 8'({4{rows[i][2]}}));
			chk("rx ready", 8'(rx_ready_n), 8'({4{rows[i][1]}}));
			chk("tx ready", 8'(tx_ready_n), 8'({4{rows[i][0]}}));
		end
		$display("test rows done");
		foreach (blk[i])
		begin
			set_in(blk[i][8:1]);
			repeat (2) @(negedge ref_clk);
			chk("block rx ready", 8'(rx_ready_n), 8'({4{blk[i][0]}}));
		end
		$display("test block done");
		for (int m = 1; m >= 0; m--)
		begin
			strobe_mode_sel = m[0];
			for (int c = 0; c < 4; c++)
			begin
				cmd(1'b1, 4'(1 << c), 3'(c + 1), 8'(8'h50 + c));
				chk("write chan", 8'({val_seen, wr_seen}), 8'(1 << c));
				chk("write byte", got_byte, 8'(8'h50 + c));
				chk("write addr", 8'(got_addr), 8'(c + 1));
				cmd(1'b0, 4'(1 << c), 3'(6 - c), 8'h00);
				chk("read chan", 8'(rd_seen), 8'(1 << c));
				chk("read byte", rd_data, reg_rdata[8 * c +: 8]);
				chk("read valid", 8'(val_seen), 8'h01);
				chk("read addr", 8'(got_addr), 8'(6 - c));
			end
			cmd(1'b0, 4'h3, 3'h0, 8'h00);
			chk("multi read", 8'({val_seen, ref_seen, rd_seen}), 8'h10);
			cmd(1'b1, 4'hf, 3'h2, 8'ha5);
			chk("broadcast", 8'({val_seen, ref_seen, wr_seen}), m ? 8'h0f : 8'h10);
			// active inputs again, so a missing force shows at the outputs
			set_in(8'b00100100);
			rst_req = 1'b1;
			for (int n = 0; n < 20 && chan_reset !== 1'b1; n++) @(negedge ref_clk);
			rst_req = 1'b0;
			chk("bus reset", {chan_int, rx_ready_n}, 8'h0f);
			chk("bus reset tx", 8'(tx_ready_n), 8'h0f);
			repeat (6) @(negedge ref_clk);
			$display("test bus style %0d done", m);
		end
		end_of_test();
	end
endmodule // test_quad_uart_host_port_ready_logic
